// ===== design/sfr_page_pkg.sv
package sfr_page_pkg;

    // ----------------------------------------------------------------
    // Address map of the direct space
    // ----------------------------------------------------------------
    localparam logic [7:0] SFR_BASE = 8'h80;
    localparam logic [7:0] PAGE_SEL_ADDR = 8'ha7;
    localparam logic [7:0] XRAM_PAGE_ADDR = 8'haa;

    // Page codes
    localparam logic [7:0] PAGE_ZERO = 8'h00;
    localparam logic [7:0] PAGE_F = 8'h0f;

    // ----------------------------------------------------------------
    // Reset values and field layout
    // ----------------------------------------------------------------
    localparam logic [7:0] PAGE_SEL_RESET = 8'h00;
    localparam logic [3:0] XRAM_PAGE_RESET = 4'h0;
    localparam logic [3:0] XRAM_UNUSED_BITS = 4'h0;
    localparam int XRAM_PAGE_LSB = 0;
    localparam int XRAM_PAGE_MSB = 3;

    // Bit-addressable registers end in 0x0 or 0x8
    localparam logic [2:0] BIT_ROW_LOW = 3'h0;
    // Low bit area of data RAM starts at 0x20, one byte per 8 bits
    localparam logic [3:0] RAM_BIT_BASE_NIB = 4'h2;

    // ----------------------------------------------------------------
    // Occupancy maps, bit n stands for direct address 0x80 + n
    // ----------------------------------------------------------------
    // Page 0: everything except the reserved and empty slots
    localparam logic [127:0] PAGE0_OCCUPIED =
        128'hffffffdf_ffffffff_ffef77ff_ffffffff;
    // Registers seen at the same address on both pages
    localparam logic [127:0] SHARED_OCCUPIED =
        128'h00c100c1_00010000_00000381_0001008f;
    // Registers present on page 0xf only
    localparam logic [127:0] PAGEF_ONLY =
        128'h00000000_00000000_24000070_00ee0060;

endpackage : sfr_page_pkg

// ===== design/sfr_map_lookup.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Page-aware occupancy lookup of one direct address
// ----------------------------------------------------------------
module sfr_map_lookup (
    input wire logic [7:0] byte_addr,
    input wire logic [7:0] page,
    output logic hit,
    output logic bank_f
);

    logic [6:0] idx;
    logic shared_hit;
    logic fonly_hit;

    // Slot index within the upper half
    assign idx = byte_addr[6:0];
    assign shared_hit = sfr_page_pkg::SHARED_OCCUPIED[idx];
    assign fonly_hit = sfr_page_pkg::PAGEF_ONLY[idx];

    // Resolve the slot against the selected page
    always_comb begin
        hit = 1'b0;
        bank_f = 1'b0;
        if (byte_addr == sfr_page_pkg::PAGE_SEL_ADDR) begin
            hit = 1'b1; // Page select answers on every page
        end else if (page == sfr_page_pkg::PAGE_ZERO) begin
            hit = sfr_page_pkg::PAGE0_OCCUPIED[idx];
        end else if (page == sfr_page_pkg::PAGE_F) begin
            hit = shared_hit | fonly_hit;
            bank_f = fonly_hit;
        end
    end

endmodule : sfr_map_lookup

// ===== design/bit_access_unit.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Splits a direct operand into byte address and bit position
// ----------------------------------------------------------------
module bit_access_unit (
    input wire logic [7:0] dir_addr,
    input wire logic dir_bit,
    output logic [7:0] byte_addr,
    output logic [2:0] bit_pos,
    output logic in_sfr
);

    // Bit operands above 0x7f sit in rows ending in 0x0 or 0x8
    always_comb begin
        if (dir_bit) begin
            bit_pos = dir_addr[2:0];
            if (dir_addr[7]) begin
                byte_addr = {dir_addr[7:3], sfr_page_pkg::BIT_ROW_LOW};
            end else begin
                byte_addr = {sfr_page_pkg::RAM_BIT_BASE_NIB,
                             dir_addr[6:3]};
            end
        end else begin
            bit_pos = 3'h0;
            byte_addr = dir_addr;
        end
        in_sfr = byte_addr[7]; // Upper half goes to registers
    end

endmodule : bit_access_unit

// ===== design/sfr_page_decode_xram_page.sv
`timescale 1ns/10ps

// Notes on behaviour
// R1 - XRAM page upper nibble reads zero, ignores writes
// R2 - 8-bit external move high byte from page
// R3 - Each page value selects one 256-byte block
// R4 - Low address byte from named index register
// R5 - XRAM page register at 0xaa, page zero
// R6 - Direct 0x80..0xff goes to register space
// R7 - Rows ending 0x0/0x8 are also bit addressable
// R8 - Software avoids reserved, unoccupied register slots
// R9 - Paging lets one address reach several registers
// R10 - Reset selects page zero for all accesses
// R11 - Shared registers on both pages, page-f-only hidden
// R12 - Page select at 0xa7, every page, resets zero
// R13 - Software masks interrupts around page f accesses
// R14 - Classic register set kept at customary addresses
// R15 - Page change applies to the very next access
module sfr_page_decode_xram_page (
    input wire logic clk,
    input wire logic resetn,
    input wire logic dir_valid,
    input wire logic dir_write,
    input wire logic dir_bit,
    input wire logic [7:0] dir_addr,
    input wire logic [7:0] dir_wdata,
    input wire logic ext_move_valid,
    input wire logic ext_move_index_one,
    input wire logic [7:0] index_register_zero,
    input wire logic [7:0] index_register_one,
    output logic sfr_sel,
    output logic ram_sel,
    output logic [7:0] target_addr,
    output logic [2:0] target_bit,
    output logic bit_access,
    output logic sfr_hit,
    output logic sfr_reserved,
    output logic sfr_bank_f,
    output logic [7:0] sfr_page_select,
    output logic [3:0] xram_page_select,
    output logic own_rvalid,
    output logic [7:0] own_rdata,
    output logic xram_addr_valid,
    output logic [15:0] xram_addr
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] sfr_page;
        logic [3:0] xram_page;
        logic sfr_sel;
        logic ram_sel;
        logic [7:0] target_addr;
        logic [2:0] target_bit;
        logic bit_access;
        logic sfr_hit;
        logic sfr_reserved;
        logic sfr_bank_f;
        logic own_rvalid;
        logic [7:0] own_rdata;
        logic xram_valid;
        logic [15:0] xram_addr;
    } state_s;

    localparam state_s ST_RESET = '{
        sfr_page: sfr_page_pkg::PAGE_SEL_RESET,
        xram_page: sfr_page_pkg::XRAM_PAGE_RESET,
        default: '0
    };

    state_s st_q;
    state_s st_d;

    logic [7:0] byte_addr;
    logic [2:0] bit_pos;
    logic in_sfr;
    logic map_hit;
    logic map_bank_f;
    logic page_sel_acc;
    logic xram_page_acc;
    logic [7:0] low_index;

    // ----------------------------------------------------------------
    // Operand split and page lookup
    // ----------------------------------------------------------------
    bit_access_unit bit_access_unit_inst (
        .dir_addr(dir_addr),
        .dir_bit(dir_bit),
        .byte_addr(byte_addr),
        .bit_pos(bit_pos),
        .in_sfr(in_sfr)
    );

    // Lookup always uses the live page value
    sfr_map_lookup sfr_map_lookup_inst (
        .byte_addr(byte_addr),
        .page(st_q.sfr_page), // see R15
        .hit(map_hit),
        .bank_f(map_bank_f)
    );

    // Own registers are byte-only, so bit operands never reach them
    assign page_sel_acc = dir_valid && in_sfr && !dir_bit
        && (byte_addr == sfr_page_pkg::PAGE_SEL_ADDR); // see R12
    assign xram_page_acc = dir_valid && in_sfr && !dir_bit
        && (byte_addr == sfr_page_pkg::XRAM_PAGE_ADDR)
        && (st_q.sfr_page == sfr_page_pkg::PAGE_ZERO); // see R5

    // Index register picked by the instruction
    assign low_index = ext_move_index_one ? index_register_one
                                          : index_register_zero; // see R4

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.own_rvalid = 1'b0;
        st_d.own_rdata = 8'h00;
        st_d.xram_valid = 1'b0;
        st_d.sfr_sel = 1'b0;
        st_d.ram_sel = 1'b0;
        st_d.sfr_hit = 1'b0;
        st_d.sfr_reserved = 1'b0;
        st_d.sfr_bank_f = 1'b0;
        st_d.bit_access = 1'b0;

        // Route the direct access
        if (dir_valid) begin
            st_d.sfr_sel = in_sfr; // see R6
            st_d.ram_sel = !in_sfr;
            st_d.target_addr = byte_addr;
            st_d.target_bit = bit_pos; // see R7
            st_d.bit_access = dir_bit;
            st_d.sfr_hit = in_sfr && map_hit; // see R9, R11, R14
            st_d.sfr_reserved = in_sfr && !map_hit; // see R8
            st_d.sfr_bank_f = in_sfr && map_bank_f; // see R11
        end

        // Page select register, present on every page
        if (page_sel_acc) begin
            if (dir_write) begin
                st_d.sfr_page = dir_wdata; // see R12
            end else begin
                st_d.own_rvalid = 1'b1;
                st_d.own_rdata = st_q.sfr_page;
            end
        end

        // XRAM page register, upper nibble fixed at zero
        if (xram_page_acc) begin
            if (dir_write) begin
                st_d.xram_page =
                    dir_wdata[sfr_page_pkg::XRAM_PAGE_MSB:
                              sfr_page_pkg::XRAM_PAGE_LSB]; // see R1
            end else begin
                st_d.own_rvalid = 1'b1;
                st_d.own_rdata = {sfr_page_pkg::XRAM_UNUSED_BITS,
                                  st_q.xram_page}; // see R1
            end
        end

        // 8-bit external move address build
        if (ext_move_valid) begin
            st_d.xram_valid = 1'b1;
            st_d.xram_addr = {sfr_page_pkg::XRAM_UNUSED_BITS,
                              st_q.xram_page, low_index}; // see R2, R3
        end
    end

    // Register the whole state
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_q <= ST_RESET; // see R10
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign sfr_sel = st_q.sfr_sel;
    assign ram_sel = st_q.ram_sel;
    assign target_addr = st_q.target_addr;
    assign target_bit = st_q.target_bit;
    assign bit_access = st_q.bit_access;
    assign sfr_hit = st_q.sfr_hit;
    assign sfr_reserved = st_q.sfr_reserved;
    assign sfr_bank_f = st_q.sfr_bank_f;
    assign sfr_page_select = st_q.sfr_page;
    assign xram_page_select = st_q.xram_page;
    assign own_rvalid = st_q.own_rvalid;
    assign own_rdata = st_q.own_rdata;
    assign xram_addr_valid = st_q.xram_valid;
    assign xram_addr = st_q.xram_addr;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // Read of the XRAM page returns a zero upper nibble
    property p_xram_upper_zero;
        @(posedge clk) disable iff (!resetn)
        (dir_valid && !dir_write && !dir_bit && dir_addr == 8'haa
            && sfr_page_select == 8'h00)
        |=> own_rvalid && own_rdata[7:4] == 4'h0
            && own_rdata[3:0] == $past(xram_page_select);
    endproperty
    a_xram_upper_zero: assert property (p_xram_upper_zero) // see R1
        else $error("xram page readback wrong");

    // High address byte follows the page held when the move was taken
    property p_move_high_byte;
        @(posedge clk) disable iff (!resetn)
        ext_move_valid |=> xram_addr_valid
            && xram_addr[15:8] == {4'h0, $past(xram_page_select)};
    endproperty
    a_move_high_byte: assert property (p_move_high_byte) // see R2
        else $error("external move high byte wrong");

    // Addresses stay inside the sixteen 256-byte pages
    property p_move_page_span;
        @(posedge clk) disable iff (!resetn)
        xram_addr_valid |-> xram_addr[15:12] == 4'h0;
    endproperty
    a_move_page_span: assert property (p_move_page_span) // see R3
        else $error("external move beyond page range");

    // Low byte from the named index register
    property p_move_low_byte;
        @(posedge clk) disable iff (!resetn)
        ext_move_valid |=> xram_addr[7:0] ==
            ($past(ext_move_index_one) ? $past(index_register_one)
                                       : $past(index_register_zero));
    endproperty
    a_move_low_byte: assert property (p_move_low_byte) // see R4
        else $error("external move low byte wrong");

    // Write at 0xaa changes the XRAM page only on page zero
    property p_xram_page_write;
        @(posedge clk) disable iff (!resetn)
        (dir_valid && dir_write && !dir_bit && dir_addr == 8'haa)
        |=> xram_page_select == ($past(sfr_page_select) == 8'h00
            ? $past(dir_wdata[3:0]) : $past(xram_page_select));
    endproperty
    a_xram_page_write: assert property (p_xram_page_write) // see R5
        else $error("xram page write decode wrong");

    // Direct byte access above 0x7f selects the register space
    property p_direct_upper;
        @(posedge clk) disable iff (!resetn)
        (dir_valid && !dir_bit) |=> sfr_sel == $past(dir_addr[7])
            && ram_sel == !$past(dir_addr[7])
            && target_addr == $past(dir_addr);
    endproperty
    a_direct_upper: assert property (p_direct_upper) // see R6
        else $error("direct access routed wrong");

    // Register bit access lands in a row ending in 0x0 or 0x8
    property p_bit_row;
        @(posedge clk) disable iff (!resetn)
        (dir_valid && dir_bit && dir_addr[7]) |=> sfr_sel && bit_access
            && target_addr[2:0] == 3'h0
            && target_bit == $past(dir_addr[2:0]);
    endproperty
    a_bit_row: assert property (p_bit_row) // see R7
        else $error("bit access row wrong");

    // Same address resolves to the page-f bank when page f is set
    property p_page_f_bank;
        @(posedge clk) disable iff (!resetn)
        (dir_valid && !dir_bit && dir_addr == 8'hba
            && sfr_page_select == 8'h0f) |=> sfr_hit && sfr_bank_f;
    endproperty
    a_page_f_bank: assert property (p_page_f_bank) // see R9
        else $error("page f register not selected");

    // Reset always lands on page zero and XRAM page zero
    property p_reset_page;
        @(posedge clk)
        !resetn |=> sfr_page_select == 8'h00 && xram_page_select == 4'h0
            && !own_rvalid && !xram_addr_valid;
    endproperty
    a_reset_page: assert property (p_reset_page) // see R10
        else $error("reset page not zero");

    // Shared registers resolve to the common bank on page f
    property p_shared_reach;
        @(posedge clk) disable iff (!resetn)
        (dir_valid && !dir_bit && dir_addr == 8'ha9
            && sfr_page_select == 8'h0f) |=> sfr_hit && !sfr_bank_f;
    endproperty
    a_shared_reach: assert property (p_shared_reach) // see R11
        else $error("shared register not reachable");

    // Page-f-only slot resolves to the page zero register on page zero
    property p_fonly_hidden;
        @(posedge clk) disable iff (!resetn)
        (dir_valid && !dir_bit && dir_addr == 8'ha4
            && sfr_page_select == 8'h00) |=> sfr_hit && !sfr_bank_f;
    endproperty
    a_fonly_hidden: assert property (p_fonly_hidden) // see R11
        else $error("page f register leaked to page zero");

    // Page select written from any page, usable next cycle
    property p_page_write;
        @(posedge clk) disable iff (!resetn)
        (dir_valid && dir_write && !dir_bit && dir_addr == 8'ha7)
        |=> sfr_page_select == $past(dir_wdata);
    endproperty
    a_page_write: assert property (p_page_write) // see R12, R15
        else $error("page select write lost");

endmodule : sfr_page_decode_xram_page

// ===== testbench/core_model.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Core model issuing direct and external move accesses
// ----------------------------------------------------------------
module core_model (
    input wire logic clk,
    output logic dir_valid,
    output logic dir_write,
    output logic dir_bit,
    output logic [7:0] dir_addr,
    output logic [7:0] dir_wdata,
    output logic ext_move_valid,
    output logic ext_move_index_one,
    output logic [7:0] index_register_zero,
    output logic [7:0] index_register_one
);
    logic global_interrupt_enable;
    logic saved_enable;

    // Idle requests at time zero
    initial begin
        dir_valid = 1'b0;
        dir_write = 1'b0;
        dir_bit = 1'b0;
        dir_addr = 8'h00;
        dir_wdata = 8'h00;
        ext_move_valid = 1'b0;
        ext_move_index_one = 1'b0;
        index_register_zero = 8'h00;
        index_register_one = 8'h00;
        global_interrupt_enable = 1'b1;
        saved_enable = 1'b1;
    end

    // Present one request, taken at the next edge; reserved slots
    // are only touched when the bench asks for it
    task issue(input logic w, input logic b, input logic [7:0] a,
            input logic [7:0] d);
        @(posedge clk);
        dir_valid <= 1'b1;
        dir_write <= w;
        dir_bit <= b;
        dir_addr <= a;
        dir_wdata <= d;
    endtask : issue

    // Request, release after the taking edge, settle before sampling
    task acc(input logic w, input logic b, input logic [7:0] a,
            input logic [7:0] d);
        issue(w, b, a, d);
        @(posedge clk);
        dir_valid <= 1'b0;
        #1;
    endtask : acc

    // Switch to page f clears the interrupt enable, page zero restores it; next call follows
    task set_page(input logic [7:0] p);
        if (p == sfr_page_pkg::PAGE_F) begin
            saved_enable = global_interrupt_enable;
            global_interrupt_enable = 1'b0;
        end
        issue(1'b1, 1'b0, sfr_page_pkg::PAGE_SEL_ADDR, p);
        if (p == sfr_page_pkg::PAGE_ZERO) begin
            global_interrupt_enable = saved_enable;
        end
    endtask : set_page

    // One 8-bit external move
    task move(input logic one, input logic [7:0] i0,
            input logic [7:0] i1);
        @(posedge clk);
        ext_move_valid <= 1'b1;
        ext_move_index_one <= one;
        index_register_zero <= i0;
        index_register_one <= i1;
        @(posedge clk);
        ext_move_valid <= 1'b0;
        #1;
    endtask : move
endmodule : core_model

// ===== testbench/sfr_page_decode_xram_page_bench.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------
module sfr_page_decode_xram_page_bench;
    logic clk;
    logic resetn;
    logic dir_valid, dir_write, dir_bit;
    logic [7:0] dir_addr, dir_wdata;
    logic ext_move_valid, ext_move_index_one;
    logic [7:0] index_register_zero, index_register_one;
    logic sfr_sel, ram_sel, bit_access, sfr_hit, sfr_reserved;
    logic sfr_bank_f, own_rvalid, xram_addr_valid;
    logic [7:0] target_addr, sfr_page_select, own_rdata;
    logic [2:0] target_bit;
    logic [3:0] xram_page_select;
    logic [15:0] xram_addr;
    int n_fail;
    int checks_done;
    int cyc;
    logic [7:0] pg;

    core_model core_model_inst (.clk(clk), .dir_valid(dir_valid),
        .dir_write(dir_write), .dir_bit(dir_bit), .dir_addr(dir_addr),
        .dir_wdata(dir_wdata), .ext_move_valid(ext_move_valid),
        .ext_move_index_one(ext_move_index_one),
        .index_register_zero(index_register_zero),
        .index_register_one(index_register_one));

    sfr_page_decode_xram_page sfr_page_decode_xram_page_inst (
        .clk(clk), .resetn(resetn), .dir_valid(dir_valid),
        .dir_write(dir_write), .dir_bit(dir_bit), .dir_addr(dir_addr),
        .dir_wdata(dir_wdata), .ext_move_valid(ext_move_valid),
        .ext_move_index_one(ext_move_index_one),
        .index_register_zero(index_register_zero),
        .index_register_one(index_register_one), .sfr_sel(sfr_sel),
        .ram_sel(ram_sel), .target_addr(target_addr),
        .target_bit(target_bit), .bit_access(bit_access),
        .sfr_hit(sfr_hit), .sfr_reserved(sfr_reserved),
        .sfr_bank_f(sfr_bank_f), .sfr_page_select(sfr_page_select),
        .xram_page_select(xram_page_select), .own_rvalid(own_rvalid),
        .own_rdata(own_rdata), .xram_addr_valid(xram_addr_valid),
        .xram_addr(xram_addr));

    // Clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Compare and count
    task check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Verdict and end of run
    task stop_test;
        if (n_fail == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    // Hang guard
    initial cyc = 0;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_fail++;
            stop_test;
        end
    end

    // Main sequence
    initial begin
        resetn = 1'b0;
        n_fail = 0;
        checks_done = 0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        core_model_inst.acc(1'b0, 1'b0, 8'ha7, 8'h00);
        check({own_rvalid, own_rdata}, {1'b1, 8'h00});
        core_model_inst.acc(1'b0, 1'b0, 8'haa, 8'h00);
        check({own_rvalid, own_rdata}, {1'b1, 8'h00});
        core_model_inst.acc(1'b1, 1'b0, 8'haa, 8'hf5);
        check(xram_page_select, 4'h5);
        core_model_inst.acc(1'b0, 1'b0, 8'haa, 8'h00);
        check(own_rdata, 8'h05);
        core_model_inst.move(1'b0, 8'h34, 8'hff);
        check({xram_addr_valid, xram_addr}, {1'b1, 16'h0534});
        core_model_inst.move(1'b1, 8'h34, 8'hff);
        check(xram_addr, 16'h05ff);
        // Lowest and highest ends of two pages
        for (int i = 0; i < 2; i++) begin
            pg = (i == 0) ? 8'h01 : 8'h0f;
            core_model_inst.acc(1'b1, 1'b0, 8'haa, pg);
            core_model_inst.move(1'b0, 8'h00, 8'hff);
            check(xram_addr, {pg, 8'h00});
            core_model_inst.move(1'b1, 8'h00, 8'hff);
            check(xram_addr, {pg, 8'hff});
        end
        core_model_inst.acc(1'b0, 1'b0, 8'h45, 8'h00);
        check({ram_sel, sfr_sel, target_addr}, {2'b10, 8'h45});
        core_model_inst.acc(1'b0, 1'b0, 8'h80, 8'h00);
        check({ram_sel, sfr_sel, target_addr}, {2'b01, 8'h80});
        core_model_inst.acc(1'b0, 1'b1, 8'h13, 8'h00);
        check({ram_sel, bit_access, target_addr, target_bit},
            {2'b11, 8'h22, 3'h3});
        core_model_inst.acc(1'b0, 1'b1, 8'hab, 8'h00);
        check({sfr_sel, bit_access, target_addr, target_bit},
            {2'b11, 8'ha8, 3'h3});
        core_model_inst.acc(1'b0, 1'b0, 8'hab, 8'h00);
        check({sfr_hit, sfr_reserved}, 2'b01);
        core_model_inst.acc(1'b0, 1'b0, 8'h81, 8'h00);
        check(sfr_hit, 1'b1);
        core_model_inst.acc(1'b0, 1'b0, 8'hba, 8'h00);
        check({sfr_hit, sfr_bank_f}, 2'b10);
        // Page change followed at once by a page-f-only read
        core_model_inst.set_page(8'h0f);
        core_model_inst.acc(1'b0, 1'b0, 8'hba, 8'h00);
        check({sfr_hit, sfr_bank_f}, 2'b11);
        check(sfr_page_select, 8'h0f);
        core_model_inst.acc(1'b0, 1'b0, 8'ha7, 8'h00);
        check({own_rvalid, own_rdata}, {1'b1, 8'h0f});
        core_model_inst.acc(1'b0, 1'b0, 8'haa, 8'h00);
        check(own_rvalid, 1'b0);
        core_model_inst.acc(1'b1, 1'b0, 8'haa, 8'h07);
        check(xram_page_select, 4'hf);
        core_model_inst.acc(1'b0, 1'b0, 8'ha9, 8'h00);
        check({sfr_hit, sfr_bank_f}, 2'b10);
        core_model_inst.set_page(8'h00);
        core_model_inst.acc(1'b0, 1'b0, 8'ha4, 8'h00);
        check({sfr_hit, sfr_bank_f}, 2'b10);
        check(sfr_page_select, 8'h00);
        // Unmapped page value, then a reset in mid-run
        core_model_inst.set_page(8'h05);
        core_model_inst.acc(1'b0, 1'b0, 8'h80, 8'h00);
        check({sfr_hit, sfr_reserved}, 2'b01);
        core_model_inst.acc(1'b0, 1'b0, 8'ha7, 8'h00);
        check({own_rvalid, own_rdata}, {1'b1, 8'h05});
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        check({sfr_page_select, xram_page_select}, 12'h000);
        core_model_inst.acc(1'b0, 1'b0, 8'hba, 8'h00);
        check({sfr_hit, sfr_bank_f}, 2'b10);
        stop_test;
    end
endmodule : sfr_page_decode_xram_page_bench
